// ### pgt_defs.svh
// constants for the paired general timers
// included by the timer modules pgt_tick and pgt_timers, not by the package
`ifndef PGT_DEFS_SVH
`define PGT_DEFS_SVH
`define PGT_CON_ON 15
`define PGT_CON_GATE 6
`define PGT_CON_PS_HI 5
`define PGT_CON_PS_LO 4
`define PGT_CON_T32 3
`define PGT_CON_CS 1
`define PGT_CON_RST 16'h0000
`define PGT_PR_RST 16'hFFFF
`define PGT_CNT_RST 16'h0000
`endif

// ### pgt_pkg.sv
// types for the paired general timers
// needs no include; nothing from pgt_defs.svh is used here
package pgt_pkg;
    typedef enum logic [1:0] {
        PGT_DIV1,
        PGT_DIV8,
        PGT_DIV64,
        PGT_DIV256
    } pgt_ps_t;
endpackage

// ### pgt_tick.sv
// prescaler and gate qualifier for one timer
// inputs already synchronised to clk_sys
`timescale 1ns/1ps
`include "pgt_defs.svh"
module pgt_tick
    import pgt_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic enable,
    input wire logic use_ext,
    input wire logic gate_mode,
    input wire logic [1:0] ps_sel,
    input wire logic ext_clk_s,
    input wire logic gate_s,
    output logic tick
);
    logic ext_prev_q, ext_prev_d;
    logic [7:0] ps_q, ps_d;
    logic src;
    logic [7:0] lim;
    always_comb begin
        ext_prev_d = ext_clk_s;
        // source edge: rising edge of count clock, or sys clock, gated when gate_mode
        if (use_ext) begin
            src = ext_clk_s & ~ext_prev_q;
        end else if (gate_mode) begin
            src = gate_s;
        end else begin
            src = 1'b1;
        end
        case (pgt_ps_t'(ps_sel))
            PGT_DIV1: lim = 8'h00;
            PGT_DIV8: lim = 8'h07;
            PGT_DIV64: lim = 8'h3F;
            PGT_DIV256: lim = 8'hFF;
            default: lim = 8'h00;
        endcase
        ps_d = ps_q;
        tick = 1'b0;
        if (!enable) begin
            ps_d = 8'h00;
        end else if (src) begin
            if (ps_q >= lim) begin
                ps_d = 8'h00;
                tick = 1'b1;
            end else begin
                ps_d = ps_q + 8'h01;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ext_prev_q <= 1'b0;
            ps_q <= 8'h00;
        end else begin
            ext_prev_q <= ext_prev_d;
            ps_q <= ps_d;
        end
    end
endmodule

// ### pgt_timers.sv
// How it works
// - two pairs, each 32-bit or two 16-bit
// - pair modes: split, 32-bit timer, counter
// - each 16-bit timer: timer or counter
// - lower timers hold low word
// - upper control ignored in 32-bit mode
// - pair uses lower timer clock, gate
// - 32-bit match flags upper timer
// - gate, prescaler
// - only timers two/three feed capture/compare
// - converter trigger: pairs or timers three/five
// - all four timers may request DMA
// four 16-bit timers joined as two pairs
// control, period and flag-clear come as ports from the core
`timescale 1ns/1ps
`include "pgt_defs.svh"
module pgt_timers
    import pgt_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:0] timer_two_control,
    input wire logic [15:0] timer_three_control,
    input wire logic [15:0] timer_four_control,
    input wire logic [15:0] timer_five_control,
    input wire logic [63:0] period,
    input wire logic [3:0] ext_clk,
    input wire logic [3:0] ext_gate,
    input wire logic [3:0] flag_clr,
    output logic [63:0] count,
    output logic [3:0] irq_flag,
    output logic [3:0] dma_req,
    output logic [1:0] capture_base_tick,
    output logic first_converter_trig
);
    logic [3:0] clk_m_q, clk_s_q, gate_m_q, gate_s_q;
    logic [15:0] con [4];
    logic [15:0] cnt_q [4];
    logic [15:0] cnt_d [4];
    logic [15:0] pr [4];
    logic [3:0] tick, match, flag_q, flag_d, dma_q, dma_d;
    logic [3:0] clr_cnt;
    logic [1:0] cap_q, cap_d;
    logic trig_q, trig_d;
    logic [1:0] pair32;
    assign con[0] = timer_two_control;
    assign con[1] = timer_three_control;
    assign con[2] = timer_four_control;
    assign con[3] = timer_five_control;
    // pair mode bit lives only in the lower control
    assign pair32[0] = timer_two_control[`PGT_CON_T32];
    assign pair32[1] = timer_four_control[`PGT_CON_T32];
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_tmr
            localparam int LO = g & 2;
            logic [15:0] c;
            logic ck, gt;
            assign pr[g] = period[g*16 +: 16];
            // upper timer borrows lower's control, clock, gate
            assign c = (pair32[g/2] && (g % 2 == 1)) ? con[LO] : con[g];
            assign ck = (pair32[g/2]) ? clk_s_q[LO] : clk_s_q[g];
            assign gt = (pair32[g/2]) ? gate_s_q[LO] : gate_s_q[g];
            pgt_tick u_tick (
                .clk_sys(clk_sys),
                .rst(rst),
                .enable(c[`PGT_CON_ON]),
                .use_ext(c[`PGT_CON_CS]),
                .gate_mode(c[`PGT_CON_GATE] & ~c[`PGT_CON_CS]),
                .ps_sel(c[`PGT_CON_PS_HI:`PGT_CON_PS_LO]),
                .ext_clk_s(ck),
                .gate_s(gt),
                .tick(tick[g])
            );
        end
    endgenerate
    always_comb begin
        logic [31:0] full;
        logic [31:0] fpr;
        full = 32'h0;
        fpr = 32'h0;
        for (int i = 0; i < 4; i++) begin
            cnt_d[i] = cnt_q[i];
            match[i] = 1'b0;
            clr_cnt[i] = 1'b0;
        end
        for (int p = 0; p < 2; p++) begin
            full = {cnt_q[2*p+1], cnt_q[2*p]};
            fpr = {pr[2*p+1], pr[2*p]};
            if (pair32[p]) begin
                if (tick[2*p]) begin
                    if (full == fpr) begin
                        match[2*p+1] = 1'b1;
                        cnt_d[2*p] = `PGT_CNT_RST;
                        cnt_d[2*p+1] = `PGT_CNT_RST;
                    end else begin
                        cnt_d[2*p] = cnt_q[2*p] + 16'h0001;
                        if (cnt_q[2*p] == 16'hFFFF) begin
                            cnt_d[2*p+1] = cnt_q[2*p+1] + 16'h0001;
                        end
                    end
                end
            end else begin
                for (int k = 0; k < 2; k++) begin
                    if (tick[2*p+k]) begin
                        if (cnt_q[2*p+k] == pr[2*p+k]) begin
                            match[2*p+k] = 1'b1;
                            cnt_d[2*p+k] = `PGT_CNT_RST;
                        end else begin
                            cnt_d[2*p+k] = cnt_q[2*p+k] + 16'h0001;
                        end
                    end
                end
            end
        end
        // set wins over clear
        flag_d = (flag_q & ~flag_clr) | match;
        dma_d = match;
        cap_d = {tick[1], tick[0]};
        trig_d = match[1] | match[3];
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            clk_m_q <= 4'h0;
            clk_s_q <= 4'h0;
            gate_m_q <= 4'h0;
            gate_s_q <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                cnt_q[i] <= `PGT_CNT_RST;
            end
            flag_q <= 4'h0;
            dma_q <= 4'h0;
            cap_q <= 2'h0;
            trig_q <= 1'b0;
        end else begin
            clk_m_q <= ext_clk;
            clk_s_q <= clk_m_q;
            gate_m_q <= ext_gate;
            gate_s_q <= gate_m_q;
            for (int i = 0; i < 4; i++) begin
                cnt_q[i] <= cnt_d[i];
            end
            flag_q <= flag_d;
            dma_q <= dma_d;
            cap_q <= cap_d;
            trig_q <= trig_d;
        end
    end
    assign count = {cnt_q[3], cnt_q[2], cnt_q[1], cnt_q[0]};
    assign irq_flag = flag_q;
    assign dma_req = dma_q;
    assign capture_base_tick = cap_q;
    assign first_converter_trig = trig_q;
endmodule

// ### pgt_timers_sva.sv
// port assertions for the paired timers
// sees only the top ports; bound below
`timescale 1ns/1ps
module pgt_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:0] timer_two_control,
    input wire logic [15:0] timer_four_control,
    input wire logic [3:0] flag_clr,
    input wire logic [63:0] count,
    input wire logic [3:0] irq_flag,
    input wire logic [3:0] dma_req,
    input wire logic first_converter_trig
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    match_zero_a: assert property (
        $rose(irq_flag[0]) |-> count[15:0] == 16'h0000)
        else $error("count not cleared on match");
    trig_source_a: assert property (
        first_converter_trig |-> irq_flag[1] || irq_flag[3])
        else $error("trigger without upper match");
    pair_flag_a: assert property (
        $past(timer_two_control[3], 2) && timer_two_control[3]
        |-> !$rose(irq_flag[0]))
        else $error("lower flag set in pair mode");
    dma_five_a: assert property (dma_req[3] |-> irq_flag[3])
        else $error("dma without match");
    dma_three_a: assert property (dma_req[1] |-> irq_flag[1])
        else $error("dma without match");
    flag_hold_a: assert property (
        irq_flag[2] && !flag_clr[2] |=> irq_flag[2])
        else $error("flag dropped");
    off_hold_a: assert property (
        !timer_two_control[15] [*4] |-> $stable(count[15:0]))
        else $error("count moved while off");
    carry_only_a: assert property (
        $past(timer_four_control[3], 2) && timer_four_control[3]
        && $changed(count[63:48]) |-> $past(count[47:32]) == 16'hFFFF
        || count[63:32] == 32'h0000_0000)
        else $error("upper moved without carry");
    cover property ($rose(irq_flag[0]));
    cover property (irq_flag[3]);
    cover property (first_converter_trig);
endmodule
bind pgt_timers pgt_chk chk_u (.clk_sys(clk_sys), .rst(rst),
    .timer_two_control(timer_two_control),
    .timer_four_control(timer_four_control), .flag_clr(flag_clr),
    .count(count), .irq_flag(irq_flag), .dma_req(dma_req),
    .first_converter_trig(first_converter_trig));

// ### pgt_pins.sv
// count clock and gate pin model
// clocked by the bench clock; idle pins stay low
`timescale 1ns/1ps
module pgt_pins (
    input wire logic clk_sys,
    input wire logic [3:0] clk_en,
    input wire logic [3:0] gate_lvl,
    output logic [3:0] ext_clk,
    output logic [3:0] ext_gate
);
    logic [1:0] ph = 2'h0;
    always @(posedge clk_sys) begin
        ph <= ph + 2'h1;
        ext_clk <= clk_en & {4{ph[1]}};
    end
    assign ext_gate = gate_lvl;
endmodule

// ### tb.sv
// bench for the paired timers
// uses pgt_pins as the pin side
`timescale 1ns/1ps
module tb;
    logic clk_sys = 0, rst = 1, trig;
    logic [15:0] c2 = 0, c3 = 0, c4 = 0, c5 = 0;
    logic [63:0] period = 0, count;
    logic [3:0] clk_en = 0, gate_lvl = 0, flag_clr = 0, ext_clk, ext_gate;
    logic [3:0] irq_flag, dma_req;
    logic [1:0] cap;
    int num_errors = 0, tests_run = 0, cyc = 0;
    always #50 clk_sys = ~clk_sys;
    pgt_pins pins_u (.clk_sys(clk_sys), .clk_en(clk_en), .gate_lvl(gate_lvl),
        .ext_clk(ext_clk), .ext_gate(ext_gate));
    pgt_timers dut_u (.clk_sys(clk_sys), .rst(rst), .timer_two_control(c2),
        .timer_three_control(c3), .timer_four_control(c4),
        .timer_five_control(c5), .period(period), .ext_clk(ext_clk),
        .ext_gate(ext_gate), .flag_clr(flag_clr), .count(count),
        .irq_flag(irq_flag), .dma_req(dma_req), .capture_base_tick(cap),
        .first_converter_trig(trig));
    task chk(input logic [63:0] s, input logic [63:0] e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected at %0t: value mismatch", $time);
        end
    endtask
    task cyc_n(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task wait_flag(input int i, input int b);
        int n;
        n = 0;
        while (irq_flag[i] !== 1'b1 && n < b) begin
            cyc_n(1);
            n++;
        end
    endtask
    task gate_test;
        @(posedge clk_sys);
        period[15:0] <= 16'h0002;
        c2 <= 16'h8040;
        cyc_n(10);
        chk(64'(count[15:0]), 64'h0);
        @(posedge clk_sys);
        gate_lvl[0] <= 1'b1;
        wait_flag(0, 50);
        chk(64'({count[15:0], irq_flag[0], dma_req[0], trig}), 64'h6);
        chk(64'(cap), 64'h1);
        @(posedge clk_sys);
        c2 <= 16'h0000;
        flag_clr[0] <= 1'b1;
        cyc_n(2);
        chk(64'(irq_flag[0]), 64'h0);
        @(posedge clk_sys);
        flag_clr[0] <= 1'b0;
    endtask
    task ext_test;
        @(posedge clk_sys);
        period[31:16] <= 16'h0003;
        c3 <= 16'h8002;
        clk_en[1] <= 1'b1;
        wait_flag(1, 100);
        chk(64'({count[31:16], irq_flag[1], trig}), 64'h3);
        @(posedge clk_sys);
        c3 <= 16'h0000;
        clk_en[1] <= 1'b0;
    endtask
    task pair_test;
        @(posedge clk_sys);
        period[63:32] <= 32'h0001_0002;
        c5 <= 16'h8000;
        c4 <= 16'h8008;
        cyc_n(100);
        chk(64'({count[63:48], irq_flag[3], cap}), 64'h0);
        wait_flag(3, 66000);
        chk(64'({count[63:32], irq_flag[3:2], trig}), 64'h5);
        chk(64'(dma_req), 64'h8);
    endtask
    task print_verdict;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            num_errors++;
            print_verdict;
        end
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        gate_test;
        ext_test;
        pair_test;
        print_verdict;
    end
endmodule
